// ===== oag_pkg.sv
/*
  Constants and types for the operand address generator.
  Assumes a 16-bit datapath and 3-bit register numbers.
*/
package oag_pkg;
  // One-hot sequencer states
  typedef enum logic [6:0] {
    ST_IDLE      = 7'h01,
    ST_PC_LOAD   = 7'h02,
    ST_MEM_WAIT  = 7'h04,
    ST_SPEC      = 7'h08,
    ST_INDEX_ADD = 7'h10,
    ST_SETTLE    = 7'h20,
    ST_DONE      = 7'h40
  } state_t;
  // Addressing modes of the specifier
  localparam logic [2:0] MODE_REG = 3'h0;
  localparam logic [2:0] MODE_REG_DEF = 3'h1;
  localparam logic [2:0] MODE_INC = 3'h2;
  localparam logic [2:0] MODE_INC_DEF = 3'h3;
  localparam logic [2:0] MODE_DEC = 3'h4;
  localparam logic [2:0] MODE_DEC_DEF = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_IDX_DEF = 3'h7;
  // Special registers
  localparam logic [2:0] REG_SP = 3'h6;
  localparam logic [2:0] REG_PC = 3'h7;
  // Pointer steps
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  // Purpose of a memory read
  localparam logic [1:0] PURP_INSTR = 2'h0;
  localparam logic [1:0] PURP_INDEX = 2'h1;
  localparam logic [1:0] PURP_PTR = 2'h2;
  // Field positions in the instruction word
  localparam int SRC_LSB = 6;
  localparam int DST_LSB = 0;
  localparam int SPEC_W = 6;
  localparam int REG_LSB = 0;
  localparam int MODE_LSB = 3;
  localparam int DEFER_BIT = 3;
endpackage

// ===== operand_address_generator.sv
/*
  Operand address generator: fetches the instruction word, then walks the
  source and destination specifiers, fetching index words and pointers and
  stepping registers, and reports the effective addresses.
  Assumes a register file with a combinational read port and a write port
  that takes effect at the clock edge ending the write cycle, and a memory
  port that answers a held request with a one-cycle acknowledge.
*/

module operand_address_generator (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic byte_op,
  input wire logic double_op,
  output logic busy,
  output logic done,
  output logic [15:0] instr_word,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic [2:0] reg_rd_sel,
  input wire logic [15:0] reg_rd_data,
  output logic reg_wr_en,
  output logic [2:0] reg_wr_sel,
  output logic [15:0] reg_wr_data,
  output logic [15:0] src_addr,
  output logic src_is_reg,
  output logic [15:0] dst_addr,
  output logic dst_is_reg
);
  import oag_pkg::*;

  typedef struct packed {
    state_t state;
    state_t ret;
    logic [1:0] purpose;
    logic on_src;
    logic byte_op;
    logic [15:0] instr;
    logic [15:0] index;
    logic [15:0] mem_addr;
    logic wr_en;
    logic [2:0] wr_sel;
    logic [15:0] wr_data;
    logic [15:0] src_addr;
    logic src_is_reg;
    logic [15:0] dst_addr;
    logic dst_is_reg;
  } ctrl_t;

  ctrl_t st;
  ctrl_t next_st;
  logic [5:0] spec;
  logic [2:0] spec_mode;
  logic [2:0] spec_reg;
  logic [15:0] step;

  ////////////////////////////////////////////////////////////////////////////
  // Specifier decode

  assign spec = st.on_src ? st.instr[SRC_LSB +: SPEC_W] : st.instr[DST_LSB +: SPEC_W];
  assign spec_mode = spec[MODE_LSB +: 3];
  assign spec_reg = spec[REG_LSB +: 3];

  assign step = (st.byte_op && spec_reg < REG_SP) ? BYTE_STEP : WORD_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic fin;
    logic [15:0] fin_addr;
    logic fin_reg;
    logic do_wr;
    logic [2:0] wr_sel;
    logic [15:0] wr_val;
    state_t go;
    fin = 1'b0;
    fin_addr = 16'h0000;
    fin_reg = 1'b0;
    do_wr = 1'b0;
    wr_sel = spec_reg;
    wr_val = 16'h0000;
    go = st.state;
    next_st = st;
    next_st.wr_en = 1'b0;
    case (st.state)
      ST_IDLE: begin
        if (start) begin
          next_st.purpose = PURP_INSTR;
          next_st.on_src = 1'b0;
          go = ST_PC_LOAD;
        end
      end
      ST_PC_LOAD: begin
        // Counter value becomes the fetch address
        next_st.mem_addr = reg_rd_data;
        go = ST_MEM_WAIT;
      end
      ST_MEM_WAIT: begin
        if (mem_ack) begin
          case (st.purpose)
            PURP_INSTR: begin
              next_st.instr = mem_rdata;
              do_wr = 1'b1;
              wr_sel = REG_PC;
              wr_val = st.mem_addr + WORD_STEP;
              go = ST_SPEC;
            end
            PURP_INDEX: begin
              next_st.index = mem_rdata;
              do_wr = 1'b1;
              wr_sel = REG_PC;
              wr_val = st.mem_addr + WORD_STEP;
              go = ST_INDEX_ADD;
            end
            default: begin
              // Pointer word is the operand address
              fin = 1'b1;
              fin_addr = mem_rdata;
            end
          endcase
        end
      end
      ST_SETTLE: begin
        go = st.ret;
        if (st.purpose == PURP_INSTR) begin
          // Decoder answers on the fetched instruction
          next_st.on_src = double_op;
          next_st.byte_op = byte_op;
          next_st.purpose = PURP_PTR;
        end
      end
      ST_SPEC: begin
        case (spec_mode)
          MODE_REG: begin
            fin = 1'b1;
            fin_reg = 1'b1;
            fin_addr = {13'h0000, spec_reg};
          end
          MODE_REG_DEF: begin
            fin = 1'b1;
            fin_addr = reg_rd_data;
          end
          MODE_INC: begin
            // counter as pointer gives immediate word
            fin = 1'b1;
            fin_addr = reg_rd_data;
            do_wr = 1'b1;
            wr_val = reg_rd_data + step;
          end
          MODE_INC_DEF: begin
            // step by two, then pointer fetch at old value
            next_st.mem_addr = reg_rd_data;
            next_st.purpose = PURP_PTR;
            do_wr = 1'b1;
            wr_val = reg_rd_data + WORD_STEP;
            go = ST_MEM_WAIT;
          end
          MODE_DEC: begin
            fin = 1'b1;
            fin_addr = reg_rd_data - step;
            do_wr = 1'b1;
            wr_val = reg_rd_data - step;
          end
          MODE_DEC_DEF: begin
            // decrement by two then pointer fetch
            next_st.mem_addr = reg_rd_data - WORD_STEP;
            next_st.purpose = PURP_PTR;
            do_wr = 1'b1;
            wr_val = reg_rd_data - WORD_STEP;
            go = ST_MEM_WAIT;
          end
          default: begin
            next_st.purpose = PURP_INDEX;
            go = ST_PC_LOAD;
          end
        endcase
      end
      ST_INDEX_ADD: begin
        if (spec_mode == MODE_IDX) begin
          fin = 1'b1;
          fin_addr = reg_rd_data + st.index;
        end else begin
          next_st.mem_addr = reg_rd_data + st.index;
          next_st.purpose = PURP_PTR;
          go = ST_MEM_WAIT;
        end
      end
      ST_DONE: begin
        go = ST_IDLE;
      end
      default: begin
        go = ST_IDLE;
      end
    endcase
    // Record a finished specifier and move on
    if (fin) begin
      if (st.on_src) begin
        next_st.src_addr = fin_addr;
        next_st.src_is_reg = fin_reg;
        next_st.on_src = 1'b0;
        go = ST_SPEC;
      end else begin
        next_st.dst_addr = fin_addr;
        next_st.dst_is_reg = fin_reg;
        go = ST_DONE;
      end
    end
    // Register writes pass through one settle cycle
    if (do_wr) begin
      next_st.wr_en = 1'b1;
      next_st.wr_sel = wr_sel;
      next_st.wr_data = wr_val;
      next_st.ret = go;
      next_st.state = ST_SETTLE;
    end else begin
      next_st.state = go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.ret <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign busy = (st.state != ST_IDLE);
  assign done = (st.state == ST_DONE);
  assign mem_req = (st.state == ST_MEM_WAIT);
  assign mem_addr = st.mem_addr;
  assign reg_rd_sel = (st.state == ST_PC_LOAD) ? REG_PC : spec_reg;
  assign instr_word = st.instr;
  assign reg_wr_en = st.wr_en;
  assign reg_wr_sel = st.wr_sel;
  assign reg_wr_data = st.wr_data;
  assign src_addr = st.src_addr;
  assign src_is_reg = st.src_is_reg;
  assign dst_addr = st.dst_addr;
  assign dst_is_reg = st.dst_is_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic in_spec;
  assign in_spec = (st.state == ST_SPEC);

  sequence s_counter_read;
    reg_rd_sel == REG_PC;
  endsequence
  // Request raised with the address set up in the settle cycle
  sequence s_fetch_held;
    mem_req && $stable(mem_addr);
  endsequence
  sequence s_counter_step;
    reg_wr_en && reg_wr_sel == REG_PC;
  endsequence
  a_instr_fetch_start: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (st.state == ST_IDLE && start) |=> s_counter_read ##1 mem_req)
    else $error("instruction fetch did not start from counter");
  // every counter fetch steps it by two
  a_pc_fetch_step: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (mem_req && mem_ack && st.purpose != PURP_PTR)
    |=> s_counter_step ##0 (reg_wr_data == $past(mem_addr) + WORD_STEP))
    else $error("counter not stepped by two after fetch");
  a_autoinc_step: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (in_spec && spec_mode == MODE_INC)
    |=> reg_wr_en && reg_wr_data == $past(reg_rd_data) + $past(step))
    else $error("autoincrement step wrong");
  // stack pointer and counter steps are two, in the mode's direction
  a_sp_step_two: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (in_spec && spec_reg >= REG_SP && (spec_mode == MODE_INC || spec_mode == MODE_DEC))
    |=> reg_wr_en && reg_wr_data == (($past(spec_mode) == MODE_INC)
      ? $past(reg_rd_data) + WORD_STEP : $past(reg_rd_data) - WORD_STEP))
    else $error("stack or counter step not two");
  // deferred decrement by two, pointer at new value
  a_dec_deferred: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (in_spec && spec_mode == MODE_DEC_DEF)
    |=> reg_wr_data == $past(reg_rd_data) - WORD_STEP && mem_addr == reg_wr_data
      ##1 s_fetch_held)
    else $error("deferred decrement wrong");
  a_mode1_addr: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (in_spec && spec_mode == MODE_REG_DEF && !st.on_src)
    |=> !reg_wr_en && dst_addr == $past(reg_rd_data) && done)
    else $error("register deferred address wrong");
  a_index_sum: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (st.state == ST_INDEX_ADD && spec_mode == MODE_IDX && !st.on_src)
    |=> dst_addr == $past(reg_rd_data) + $past(st.index) && !reg_wr_en)
    else $error("index sum wrong");
  // index deferred fetches pointer at sum
  a_index_deferred: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (st.state == ST_INDEX_ADD && spec_mode == MODE_IDX_DEF)
    |=> mem_req && !reg_wr_en && mem_addr == $past(reg_rd_data) + $past(st.index))
    else $error("index deferred pointer address wrong");
  // double operand starts with the source
  a_src_first: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (st.state == ST_SETTLE && st.purpose == PURP_INSTR && double_op)
    |=> in_spec && st.on_src)
    else $error("source specifier not first");
  // Completion is a single pulse
  a_done_pulse: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    done |=> !done && !busy)
    else $error("done longer than one cycle");
endmodule

// ===== mem_reg_model.sv
/*
  Far-side model: word memory with random wait states and an eight-entry
  register file with a combinational read port.
  Assumes one clock and the generator's held request / one-cycle acknowledge.
*/
module mem_reg_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  input wire logic [2:0] reg_rd_sel,
  output logic [15:0] reg_rd_data,
  input wire logic reg_wr_en,
  input wire logic [2:0] reg_wr_sel,
  input wire logic [15:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words [0:32767];
  logic [15:0] regs [0:7];
  logic [15:0] lf;
  // Address-dependent memory pattern, quiet outputs at time zero
  initial begin
    for (int i = 0; i < 32768; i++) begin
      words[i] = 16'(i * 40503) ^ 16'ha5c3;
    end
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    lf = 16'h1d2b;
  end
  // Register read follows the select in the same cycle
  assign reg_rd_data = regs[reg_rd_sel];
  // Answer after a random number of waits; data toggles when not valid
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      lf <= 16'h1d2b;
    end else begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      if (mem_req && !mem_ack && lf[0]) begin
        mem_ack <= 1'b1;
        mem_rdata <= words[mem_addr[15:1]];
      end else begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
    if (reg_wr_en) begin
      regs[reg_wr_sel] <= reg_wr_data;
    end
  end
endmodule

// ===== operand_address_generator_bench.sv
/*
  Self-checking bench for the operand address generator: corner specifiers,
  then random ones; expectations come from a copy of the registers.
  Assumes mem_reg_model as memory and register file on the far side.
*/
module operand_address_generator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import oag_pkg::*;
  logic ref_clk, nrst, start, byte_op, double_op, busy, done, mem_req, mem_ack;
  logic reg_wr_en, src_is_reg, dst_is_reg;
  logic [15:0] instr_word, mem_addr, mem_rdata, reg_rd_data, reg_wr_data, src_addr, dst_addr;
  logic [2:0] reg_rd_sel, reg_wr_sel;
  logic [31:0] seed = 32'h00000057;
  logic [15:0] er [0:7];
  int err_total = 0;
  int comparisons = 0;
  // Byte, double, source and destination specifiers of the hand-picked cases
  localparam logic [13:0] CORNERS [0:15] = '{14'h15c0, 14'h001f, 14'h0037, 14'h003f,
    14'h1cb5, 14'h18c0, 14'h2016, 14'h2026, 14'h35d0, 14'h2021, 14'h201a, 14'h202c,
    14'h1f49, 14'h0010, 14'h0036, 14'h3dff};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  operand_address_generator dut_u (.ref_clk, .nrst, .start, .byte_op, .double_op, .busy,
    .done, .instr_word, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .reg_rd_sel,
    .reg_rd_data, .reg_wr_en, .reg_wr_sel, .reg_wr_data, .src_addr, .src_is_reg,
    .dst_addr, .dst_is_reg);

  mem_reg_model mdl (.ref_clk, .nrst, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .reg_rd_sel, .reg_rd_data, .reg_wr_en, .reg_wr_sel, .reg_wr_data);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] rd(input logic [15:0] a);
    return mdl.words[a[15:1]];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Walk one specifier over the register copy, giving its address
  task automatic spec_calc(input logic [5:0] sp, input logic bt, output logic [15:0] ad,
                           output logic is_reg);
    logic [2:0] m;
    logic [2:0] n;
    logic [15:0] st;
    logic [15:0] x;
    m = sp[5:3];
    n = sp[2:0];
    st = (bt && n < REG_SP && (m == MODE_INC || m == MODE_DEC)) ? BYTE_STEP : WORD_STEP;
    is_reg = (m == MODE_REG);
    ad = er[n];
    case (m)
      MODE_REG: ad = {13'h0000, n};
      MODE_INC, MODE_INC_DEF: begin
        er[n] = er[n] + st;
        if (m == MODE_INC_DEF) ad = rd(ad);
      end
      MODE_DEC, MODE_DEC_DEF: begin
        er[n] = er[n] - st;
        ad = (m == MODE_DEC) ? er[n] : rd(er[n]);
      end
      MODE_IDX, MODE_IDX_DEF: begin
        x = rd(er[REG_PC]);
        er[REG_PC] = er[REG_PC] + WORD_STEP;
        ad = er[n] + x;
        if (m == MODE_IDX_DEF) ad = rd(ad);
      end
      default: ;
    endcase
  endtask

  // Load registers and instruction, run one decode, compare results
  task automatic run_one(input logic [13:0] c, input logic corner);
    logic [15:0] iw;
    logic [15:0] e_src;
    logic [15:0] e_dst;
    logic e_src_reg;
    logic e_dst_reg;
    int k;
    iw = {c[13], 3'h0, c[11:0]};
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      er[i] = 16'(rnd());
    end
    er[7][0] = 1'b0;
    if (corner) begin
      er[0] = 16'hffff;
      er[1] = 16'h0000;
    end
    mdl.words[er[7][15:1]] = iw;
    for (int i = 0; i < 8; i++) begin
      mdl.regs[i] = er[i];
    end
    er[REG_PC] = er[REG_PC] + WORD_STEP;
    e_src = 16'h0000;
    e_src_reg = 1'b0;
    if (c[12]) spec_calc(c[11:6], c[13], e_src, e_src_reg);
    spec_calc(c[5:0], c[13], e_dst, e_dst_reg);
    @(posedge ref_clk);
    start <= 1'b1;
    byte_op <= c[13];
    double_op <= c[12];
    repeat (3) @(posedge ref_clk);
    start <= 1'b0;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (done !== 1'b1 && k < 300);
    if (k >= 300) begin
      err_total++;
      end_sim();
    end
    check(instr_word, iw);
    check(dst_addr, e_dst);
    check({15'h0000, dst_is_reg}, {15'h0000, e_dst_reg});
    if (c[12]) begin
      check(src_addr, e_src);
      check({15'h0000, src_is_reg}, {15'h0000, e_src_reg});
    end
    for (int i = 0; i < 8; i++) begin
      check(mdl.regs[i], er[i]);
    end
    @(negedge ref_clk);
    check({14'h0000, busy, done}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    byte_op = 1'b0;
    double_op = 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (CORNERS[i]) begin
      run_one(CORNERS[i], 1'b1);
    end
    repeat (150) begin
      run_one(14'(rnd()), 1'b0);
    end
    end_sim();
  end
endmodule
